// File: include/edge_timing_pkg.sv
package edge_timing_pkg;

    // edge grid within one master clock period
    localparam logic [6:0] PHASE_COUNT = 7'h30;
    localparam logic [5:0] PHASE_LAST  = 6'h2f;
    localparam logic [5:0] PHASE_FIRST = 6'h00;
    localparam logic [5:0] PHASE_STEP  = 6'h01;
    localparam logic [5:0] HALF_PERIOD = 6'h18;
    localparam logic [5:0] QUAD_SIZE   = 6'h0c;
    localparam logic [3:0] QUAD_LAST   = 4'hb;

    localparam int POS_W  = 6;
    localparam int DRV_W  = 3;
    localparam int ADDR_W = 8;
    localparam int INV_BIT = 0;

    localparam logic [DRV_W-1:0] DRV_OFF = 3'h0;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_HA_INV   = 8'he5;
    localparam logic [ADDR_W-1:0] ADDR_HA_RISE  = 8'he6;
    localparam logic [ADDR_W-1:0] ADDR_HA_FALL  = 8'he7;
    localparam logic [ADDR_W-1:0] ADDR_HA_DRV   = 8'he8;
    localparam logic [ADDR_W-1:0] ADDR_HB_DRV   = 8'he9;
    localparam logic [ADDR_W-1:0] ADDR_HC_DRV   = 8'hea;
    localparam logic [ADDR_W-1:0] ADDR_HD_DRV   = 8'heb;
    localparam logic [ADDR_W-1:0] ADDR_RG_INV   = 8'hec;
    localparam logic [ADDR_W-1:0] ADDR_RG_RISE  = 8'hed;
    localparam logic [ADDR_W-1:0] ADDR_RG_FALL  = 8'hee;
    localparam logic [ADDR_W-1:0] ADDR_RG_DRV   = 8'hef;
    localparam logic [ADDR_W-1:0] ADDR_REF_POS  = 8'hf0;
    localparam logic [ADDR_W-1:0] ADDR_DATA_POS = 8'hf1;

    // reset values
    localparam logic             RST_HA_INV   = 1'h0;
    localparam logic [POS_W-1:0] RST_HA_RISE  = 6'h00;
    localparam logic [POS_W-1:0] RST_HA_FALL  = 6'h20;
    localparam logic [DRV_W-1:0] RST_H_DRV    = 3'h3;
    localparam logic             RST_RG_INV   = 1'h0;
    localparam logic [POS_W-1:0] RST_RG_RISE  = 6'h00;
    localparam logic [POS_W-1:0] RST_RG_FALL  = 6'h10;
    localparam logic [DRV_W-1:0] RST_RG_DRV   = 3'h2;
    localparam logic [POS_W-1:0] RST_REF_POS  = 6'h24;
    localparam logic [POS_W-1:0] RST_DATA_POS = 6'h00;

    // quadrant code to linear edge position 0..47
    function automatic logic [POS_W-1:0] code_to_position(
        input logic [POS_W-1:0] code);
        logic [3:0]       low;
        logic [POS_W-1:0] base;
        low  = (code[3:0] > QUAD_LAST) ? QUAD_LAST : code[3:0];
        base = 6'(6'(code[5:4]) * QUAD_SIZE);
        code_to_position = 6'(base + {2'b00, low});
    endfunction : code_to_position

    // position plus offset, wrapped on the 48-step grid
    function automatic logic [POS_W-1:0] wrap_add(
        input logic [POS_W-1:0] pos,
        input logic [POS_W-1:0] offs);
        logic [6:0] sum;
        sum = {1'b0, pos} + {1'b0, offs};
        if (sum >= PHASE_COUNT) begin
            sum = 7'(sum - PHASE_COUNT);
        end
        wrap_add = sum[POS_W-1:0];
    endfunction : wrap_add

endpackage : edge_timing_pkg

// File: rtl/edge_window.sv
`timescale 1ns/10ps

// level of one pulse on the phase grid: high from rise up to fall
module edge_window
    import edge_timing_pkg::*;
(
    input  wire logic [POS_W-1:0] phase_i,
    input  wire logic [POS_W-1:0] rise_pos_i,
    input  wire logic [POS_W-1:0] fall_pos_i,
    input  wire logic             invert_i,
    output logic                  level_o
);

    logic in_pulse;

    always_comb begin
        if (rise_pos_i == fall_pos_i) begin
            in_pulse = 1'b0;
        end else if (rise_pos_i < fall_pos_i) begin
            in_pulse = (phase_i >= rise_pos_i) && (phase_i < fall_pos_i);
        end else begin
            // pulse wraps across the period boundary
            in_pulse = (phase_i >= rise_pos_i) || (phase_i < fall_pos_i);
        end
    end

    assign level_o = in_pulse ^ invert_i;

endmodule : edge_window

// File: rtl/ccd_high_speed_edge_timing.sv
`timescale 1ns/10ps

// Operation
// - Each master clock period is split into 48 equal edge positions.
// - The reset gate clock has programmed rise and fall edges and can be inverted.
// - Horizontal clocks a and c use programmed edges and the pair a/b invert.
// - Horizontal clocks b and d are always the complements of a and c.
// - The pair a/b invert bit passes the clocks at 0 and inverts them at 1.
// - The reset gate invert bit passes the pulse at 0 and inverts it at 1.
// - Edge fields are 6 bits: bits 5:4 pick a quadrant, bits 3:0 pick 0..11.
// - Positions 0-11, 12-23, 24-35, 36-47 use codes 0-11, 16-27, 32-43, 48-59.
// - Each sample clock has one edge, its rising position, as sampling instant.
// - Each horizontal and reset gate output has a 3-bit drive code, 3.5 mA steps.
// - After reset horizontal a rise field is 0x00 and fall field is 0x20.
// - After reset reset gate rise field is 0x00 and fall field is 0x10.
// - After reset reference sample field is 0x24 and data sample field 0x00.
// - A drive code of zero puts that output in the high impedance state.
module ccd_high_speed_edge_timing
    import edge_timing_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              master_clock_input_i,
    input  wire logic              reg_wr_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [POS_W-1:0]  reg_wdata_i,
    output logic      [POS_W-1:0]  reg_rdata_o,
    output logic                   horiz_clock_a_o,
    output logic                   horiz_clock_a_oe_o,
    output logic                   horiz_clock_b_o,
    output logic                   horiz_clock_b_oe_o,
    output logic                   horiz_clock_c_o,
    output logic                   horiz_clock_c_oe_o,
    output logic                   horiz_clock_d_o,
    output logic                   horiz_clock_d_oe_o,
    output logic                   reset_gate_clock_o,
    output logic                   reset_gate_clock_oe_o,
    output logic                   reference_sample_clock_o,
    output logic                   data_sample_clock_o,
    output logic      [DRV_W-1:0]  horiz_a_drive_o,
    output logic      [DRV_W-1:0]  horiz_b_drive_o,
    output logic      [DRV_W-1:0]  horiz_c_drive_o,
    output logic      [DRV_W-1:0]  horiz_d_drive_o,
    output logic      [DRV_W-1:0]  reset_gate_drive_o
);

    // register file
    logic             horiz_pair_a_invert;
    logic [POS_W-1:0] horiz_a_rise_position;
    logic [POS_W-1:0] horiz_a_fall_position;
    logic [DRV_W-1:0] horiz_a_drive_code;
    logic [DRV_W-1:0] horiz_b_drive_code;
    logic [DRV_W-1:0] horiz_c_drive_code;
    logic [DRV_W-1:0] horiz_d_drive_code;
    logic             reset_gate_invert;
    logic [POS_W-1:0] reset_gate_rise_position;
    logic [POS_W-1:0] reset_gate_fall_position;
    logic [DRV_W-1:0] reset_gate_drive_code;
    logic [POS_W-1:0] reference_sample_position;
    logic [POS_W-1:0] data_sample_position;

    logic             master_s1;
    logic             master_s2;
    logic             master_s3;
    logic             master_rise;
    logic [POS_W-1:0] phase;
    logic [POS_W-1:0] next_phase;
    logic [POS_W-1:0] next_rdata;

    logic [POS_W-1:0] ha_rise_pos;
    logic [POS_W-1:0] ha_fall_pos;
    logic [POS_W-1:0] rg_rise_pos;
    logic [POS_W-1:0] rg_fall_pos;
    logic [POS_W-1:0] ref_pos;
    logic [POS_W-1:0] ref_end;
    logic [POS_W-1:0] data_pos;
    logic [POS_W-1:0] data_end;
    logic             ha_level;
    logic             rg_level;
    logic             ref_level;
    logic             data_level;

    // master clock pin synchroniser and rising edge detect
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            master_s1 <= 1'b0;
            master_s2 <= 1'b0;
            master_s3 <= 1'b0;
        end else begin
            master_s1 <= master_clock_input_i;
            master_s2 <= master_s1;
            master_s3 <= master_s2;
        end
    end

    assign master_rise = master_s2 && !master_s3;

    // 48-step phase counter, realigned on every master clock rise
    always_comb begin
        if (master_rise) begin
            next_phase = PHASE_FIRST;
        end else if (phase == PHASE_LAST) begin
            next_phase = PHASE_FIRST;
        end else begin
            next_phase = 6'(phase + PHASE_STEP);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= PHASE_FIRST;
        end else begin
            phase <= next_phase;
        end
    end

    // register writes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            horiz_pair_a_invert       <= RST_HA_INV;
            horiz_a_rise_position     <= RST_HA_RISE;
            horiz_a_fall_position     <= RST_HA_FALL;
            horiz_a_drive_code        <= RST_H_DRV;
            horiz_b_drive_code        <= RST_H_DRV;
            horiz_c_drive_code        <= RST_H_DRV;
            horiz_d_drive_code        <= RST_H_DRV;
            reset_gate_invert         <= RST_RG_INV;
            reset_gate_rise_position  <= RST_RG_RISE;
            reset_gate_fall_position  <= RST_RG_FALL;
            reset_gate_drive_code     <= RST_RG_DRV;
            reference_sample_position <= RST_REF_POS;
            data_sample_position      <= RST_DATA_POS;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_HA_INV) begin
                horiz_pair_a_invert <= reg_wdata_i[INV_BIT];
            end else if (reg_addr_i == ADDR_HA_RISE) begin
                horiz_a_rise_position <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_HA_FALL) begin
                horiz_a_fall_position <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_HA_DRV) begin
                horiz_a_drive_code <= reg_wdata_i[DRV_W-1:0];
            end else if (reg_addr_i == ADDR_HB_DRV) begin
                horiz_b_drive_code <= reg_wdata_i[DRV_W-1:0];
            end else if (reg_addr_i == ADDR_HC_DRV) begin
                horiz_c_drive_code <= reg_wdata_i[DRV_W-1:0];
            end else if (reg_addr_i == ADDR_HD_DRV) begin
                horiz_d_drive_code <= reg_wdata_i[DRV_W-1:0];
            end else if (reg_addr_i == ADDR_RG_INV) begin
                reset_gate_invert <= reg_wdata_i[INV_BIT];
            end else if (reg_addr_i == ADDR_RG_RISE) begin
                reset_gate_rise_position <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_RG_FALL) begin
                reset_gate_fall_position <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_RG_DRV) begin
                reset_gate_drive_code <= reg_wdata_i[DRV_W-1:0];
            end else if (reg_addr_i == ADDR_REF_POS) begin
                reference_sample_position <= reg_wdata_i;
            end else if (reg_addr_i == ADDR_DATA_POS) begin
                data_sample_position <= reg_wdata_i;
            end
        end
    end

    // readback, unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (reg_addr_i == ADDR_HA_INV) begin
            next_rdata = {5'h00, horiz_pair_a_invert};
        end else if (reg_addr_i == ADDR_HA_RISE) begin
            next_rdata = horiz_a_rise_position;
        end else if (reg_addr_i == ADDR_HA_FALL) begin
            next_rdata = horiz_a_fall_position;
        end else if (reg_addr_i == ADDR_HA_DRV) begin
            next_rdata = {3'h0, horiz_a_drive_code};
        end else if (reg_addr_i == ADDR_HB_DRV) begin
            next_rdata = {3'h0, horiz_b_drive_code};
        end else if (reg_addr_i == ADDR_HC_DRV) begin
            next_rdata = {3'h0, horiz_c_drive_code};
        end else if (reg_addr_i == ADDR_HD_DRV) begin
            next_rdata = {3'h0, horiz_d_drive_code};
        end else if (reg_addr_i == ADDR_RG_INV) begin
            next_rdata = {5'h00, reset_gate_invert};
        end else if (reg_addr_i == ADDR_RG_RISE) begin
            next_rdata = reset_gate_rise_position;
        end else if (reg_addr_i == ADDR_RG_FALL) begin
            next_rdata = reset_gate_fall_position;
        end else if (reg_addr_i == ADDR_RG_DRV) begin
            next_rdata = {3'h0, reset_gate_drive_code};
        end else if (reg_addr_i == ADDR_REF_POS) begin
            next_rdata = reference_sample_position;
        end else if (reg_addr_i == ADDR_DATA_POS) begin
            next_rdata = data_sample_position;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // quadrant decode; out-of-range low nibble clamps to 11
    assign ha_rise_pos = code_to_position(horiz_a_rise_position);
    assign ha_fall_pos = code_to_position(horiz_a_fall_position);
    assign rg_rise_pos = code_to_position(reset_gate_rise_position);
    assign rg_fall_pos = code_to_position(reset_gate_fall_position);
    assign ref_pos     = code_to_position(reference_sample_position);
    assign data_pos    = code_to_position(data_sample_position);
    // sample clocks run a half-period high from their single edge
    assign ref_end     = wrap_add(ref_pos, HALF_PERIOD);
    assign data_end    = wrap_add(data_pos, HALF_PERIOD);

    edge_window u_ha_window (
        .phase_i    (phase),
        .rise_pos_i (ha_rise_pos),
        .fall_pos_i (ha_fall_pos),
        .invert_i   (horiz_pair_a_invert),
        .level_o    (ha_level)
    );

    edge_window u_rg_window (
        .phase_i    (phase),
        .rise_pos_i (rg_rise_pos),
        .fall_pos_i (rg_fall_pos),
        .invert_i   (reset_gate_invert),
        .level_o    (rg_level)
    );

    edge_window u_ref_window (
        .phase_i    (phase),
        .rise_pos_i (ref_pos),
        .fall_pos_i (ref_end),
        .invert_i   (1'b0),
        .level_o    (ref_level)
    );

    edge_window u_data_window (
        .phase_i    (phase),
        .rise_pos_i (data_pos),
        .fall_pos_i (data_end),
        .invert_i   (1'b0),
        .level_o    (data_level)
    );

    // registered clock levels; c shares the a edges, b and d complement
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            horiz_clock_a_o          <= 1'b0;
            horiz_clock_b_o          <= 1'b1;
            horiz_clock_c_o          <= 1'b0;
            horiz_clock_d_o          <= 1'b1;
            reset_gate_clock_o       <= 1'b0;
            reference_sample_clock_o <= 1'b0;
            data_sample_clock_o      <= 1'b0;
        end else begin
            horiz_clock_a_o          <= ha_level;
            horiz_clock_b_o          <= !ha_level;
            horiz_clock_c_o          <= ha_level;
            horiz_clock_d_o          <= !ha_level;
            reset_gate_clock_o       <= rg_level;
            reference_sample_clock_o <= ref_level;
            data_sample_clock_o      <= data_level;
        end
    end

    // output enables follow the drive codes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            horiz_clock_a_oe_o    <= 1'b0;
            horiz_clock_b_oe_o    <= 1'b0;
            horiz_clock_c_oe_o    <= 1'b0;
            horiz_clock_d_oe_o    <= 1'b0;
            reset_gate_clock_oe_o <= 1'b0;
        end else begin
            horiz_clock_a_oe_o    <= (horiz_a_drive_code != DRV_OFF);
            horiz_clock_b_oe_o    <= (horiz_b_drive_code != DRV_OFF);
            horiz_clock_c_oe_o    <= (horiz_c_drive_code != DRV_OFF);
            horiz_clock_d_oe_o    <= (horiz_d_drive_code != DRV_OFF);
            reset_gate_clock_oe_o <= (reset_gate_drive_code != DRV_OFF);
        end
    end

    assign horiz_a_drive_o    = horiz_a_drive_code;
    assign horiz_b_drive_o    = horiz_b_drive_code;
    assign horiz_c_drive_o    = horiz_c_drive_code;
    assign horiz_d_drive_o    = horiz_d_drive_code;
    assign reset_gate_drive_o = reset_gate_drive_code;

    // checks
    logic after_reset;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            after_reset <= 1'b1;
        end else begin
            after_reset <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence rg_rise_hit;
        (phase == rg_rise_pos) && (rg_rise_pos != rg_fall_pos);
    endsequence

    sequence rg_fall_hit;
        (phase == rg_fall_pos) && (rg_rise_pos != rg_fall_pos);
    endsequence

    sequence ha_rise_hit;
        (phase == ha_rise_pos) && (ha_rise_pos != ha_fall_pos);
    endsequence

    a_phase_wrap: assert property (
        !master_rise && phase == PHASE_LAST |=> phase == PHASE_FIRST)
        else $error("phase did not wrap after last position");

    a_phase_step: assert property (
        !master_rise && phase != PHASE_LAST
        |=> phase == 6'($past(phase) + PHASE_STEP))
        else $error("phase did not advance by one");

    a_phase_resync: assert property (
        master_rise |=> phase == PHASE_FIRST)
        else $error("phase not realigned on master clock rise");

    a_rg_rise_edge: assert property (
        rg_rise_hit ##0 !reset_gate_invert |=> reset_gate_clock_o)
        else $error("reset gate not high at its rise position");

    a_rg_invert: assert property (
        rg_fall_hit ##0 reset_gate_invert |=> reset_gate_clock_o)
        else $error("inverted reset gate not high at fall position");

    a_ha_invert: assert property (
        ha_rise_hit ##0 horiz_pair_a_invert
        |=> !horiz_clock_a_o && horiz_clock_b_o)
        else $error("inverted horizontal pair wrong at rise position");

    a_hb_complement: assert property (
        horiz_clock_b_o == !horiz_clock_a_o
        && horiz_clock_d_o == !horiz_clock_c_o)
        else $error("b or d horizontal clock not a complement");

    a_ref_sample: assert property (
        phase == ref_pos |=> reference_sample_clock_o)
        else $error("reference sample clock not high at its position");

    a_data_sample: assert property (
        phase == data_end |=> !data_sample_clock_o)
        else $error("data sample clock still high after its half period");

    a_quad_map: assert property (
        horiz_a_rise_position[5:4] == 2'b01
        && horiz_a_rise_position[3:0] == 4'h0 |-> ha_rise_pos == QUAD_SIZE)
        else $error("quadrant two base code not mapped to twelve");

    a_pos_bound: assert property (
        ha_rise_pos <= PHASE_LAST && rg_fall_pos <= PHASE_LAST
        && data_pos <= PHASE_LAST)
        else $error("decoded edge position beyond the grid");

    a_off_hiz: assert property (
        reset_gate_drive_code == DRV_OFF |=> !reset_gate_clock_oe_o)
        else $error("reset gate driven with drive code zero");

    a_drive_write: assert property (
        reg_wr_i && reg_addr_i == ADDR_HB_DRV
        |=> horiz_b_drive_o == $past(reg_wdata_i[DRV_W-1:0]))
        else $error("drive code write not seen on drive output");

    a_rg_inv_write: assert property (
        reg_wr_i && reg_addr_i == ADDR_RG_INV
        |=> reset_gate_invert == $past(reg_wdata_i[INV_BIT]))
        else $error("reset gate invert write lost");

    a_reset_horiz: assert property (
        after_reset |-> horiz_a_rise_position == RST_HA_RISE
        && horiz_a_fall_position == RST_HA_FALL)
        else $error("horizontal edge fields wrong after reset");

    a_reset_rgate: assert property (
        after_reset |-> reset_gate_rise_position == RST_RG_RISE
        && reset_gate_fall_position == RST_RG_FALL)
        else $error("reset gate edge fields wrong after reset");

    a_reset_sample: assert property (
        after_reset |-> reference_sample_position == RST_REF_POS
        && data_sample_position == RST_DATA_POS)
        else $error("sample position fields wrong after reset");

endmodule : ccd_high_speed_edge_timing

// File: tb/pixel_clock_source.sv
`timescale 1ns/10ps
module pixel_clock_source (
    input  wire logic clk_i,
    output logic      master_clock_o
);
    logic [5:0] step;

    initial begin
        step = 6'h00;
        master_clock_o = 1'b0;
    end
    // one master period per 48 core clocks, half high
    always @(negedge clk_i) begin
        step <= (step == 6'h2f) ? 6'h00 : 6'(step + 6'h01);
        master_clock_o <= (step < 6'h18);
    end
endmodule : pixel_clock_source

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import edge_timing_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              nrst_i = 1'b0;
    logic              wr = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [POS_W-1:0]  wdata = 6'h00;
    logic [POS_W-1:0]  rdata;
    logic              mclk, ha, hb, hc, hd, rg, rf, dt;
    logic              ha_oe, hb_oe, hc_oe, hd_oe, rg_oe;
    logic [10:0]       s;
    logic              chk = 1'b0;
    logic              meas = 1'b0;
    logic [5:0]        cnt [11];
    int                k = 0;
    int                cyc = 0;
    int                num_errors = 0;
    int                n_compared = 0;
    logic [5:0]        rq [$];
    logic [65:0]       mq [$];
    logic [5:0]        v [13];
    logic [5:0]        rv [13] = '{6'h00, 6'h00, 6'h20, 6'h03, 6'h03, 6'h03,
        6'h03, 6'h00, 6'h00, 6'h10, 6'h02, 6'h24, 6'h00};

    always #5 clk_i = ~clk_i;

    pixel_clock_source pixel_clock_source_i (
        .clk_i(clk_i), .master_clock_o(mclk));

    ccd_high_speed_edge_timing ccd_high_speed_edge_timing_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .master_clock_input_i(mclk),
        .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .horiz_clock_a_o(ha), .horiz_clock_a_oe_o(ha_oe),
        .horiz_clock_b_o(hb), .horiz_clock_b_oe_o(hb_oe),
        .horiz_clock_c_o(hc), .horiz_clock_c_oe_o(hc_oe),
        .horiz_clock_d_o(hd), .horiz_clock_d_oe_o(hd_oe),
        .reset_gate_clock_o(rg), .reset_gate_clock_oe_o(rg_oe),
        .reference_sample_clock_o(rf), .data_sample_clock_o(dt),
        .horiz_a_drive_o(), .horiz_b_drive_o(), .horiz_c_drive_o(),
        .horiz_d_drive_o(), .reset_gate_drive_o());

    assign s = {ha, rg, rf, dt, ha_oe, hb_oe, hc_oe, hd_oe, rg_oe,
                hc ^ hb, hd ^ hc};

    task automatic end_of_test;
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic cmp_rd(input logic [5:0] e, input logic [5:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t rd exp %h got %h", $time, e, g);
        end
    endtask : cmp_rd

    task automatic cmp_cnt(input logic [65:0] e, input logic [65:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t cnt exp %h got %h", $time, e, g);
        end
    endtask : cmp_cnt

    always @(negedge clk_i) begin
        if (chk)
            cmp_rd(rq.pop_front(), rdata);
        if (meas) begin
            for (int j = 0; j < 11; j++)
                cnt[j] = 6'(cnt[j] + s[j]);
            k++;
            if (k == 48) begin
                cmp_cnt(mq.pop_front(), {<<6{cnt}});
                k = 0;
            end
        end
        if (!meas && k == 0)
            foreach (cnt[j]) cnt[j] = 6'h00;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [5:0] d);
        @(negedge clk_i);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_i);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd(input logic [7:0] a, input logic [5:0] e);
        @(negedge clk_i);
        addr = a;
        rq.push_back(e);
        chk <= 1'b1;
        @(negedge clk_i);
        chk <= 1'b0;
    endtask : rd

    function automatic int lin(input logic [5:0] c);
        return int'(c[5:4]) * 12 + int'(c[3:0]);
    endfunction : lin

    function automatic logic [5:0] width(input logic [5:0] r, f,
                                         input logic inv);
        int w;
        w = (lin(f) - lin(r) + 48) % 48;
        if (inv)
            w = 48 - w;
        return 6'(w);
    endfunction : width

    function automatic logic [5:0] oe(input logic [5:0] d);
        return (d == 6'h00) ? 6'h00 : 6'h30;
    endfunction : oe

    // program all fields from v, read them back, then measure one period
    task automatic run;
        for (int i = 0; i < 13; i++)
            wr_reg(8'(8'he5 + i), v[i]);
        for (int i = 0; i < 13; i++)
            rd(8'(8'he5 + i), v[i]);
        repeat (2) @(negedge clk_i);
        mq.push_back({width(v[1], v[2], v[0][0]), width(v[8], v[9],
            v[7][0]), 6'h18, 6'h18, oe(v[3]), oe(v[4]), oe(v[5]), oe(v[6]),
            oe(v[10]), 6'h30, 6'h30});
        meas <= 1'b1;
        repeat (47) @(negedge clk_i);
        @(negedge clk_i) meas <= 1'b0;
        @(negedge clk_i);
    endtask : run

    initial begin
        void'($urandom(73037));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) nrst_i = 1'b1;
        for (int i = 0; i < 13; i++)
            rd(8'(8'he5 + i), rv[i]);
        rd(8'he4, 6'h00);
        wr_reg(8'hf2, 6'h3f);
        rd(8'hf2, 6'h00);
        v = rv;
        repeat (60) @(negedge clk_i);
        run();
        for (int i = 0; i < 6; i++) begin
            foreach (v[j]) v[j] = {2'($urandom % 4), 4'($urandom % 12)};
            foreach (v[j]) if (j inside {0, 7}) v[j] = 6'($urandom % 2);
            foreach (v[j]) if (j inside {3, 4, 5, 6, 10}) v[j] = 6'($urandom % 8);
            // equal edges give no pulse; all drives off next
            if (i == 0) begin
                v[1] = 6'h10;
                v[2] = v[1];
                v[9] = v[8];
            end
            if (i == 1)
                foreach (v[j]) if (j inside {3, 4, 5, 6, 10}) v[j] = 6'h00;
            run();
        end
        end_of_test();
    end
endmodule : tb_top
